// *** shared/pmfd_match_if.sv ***
// carries one frame's match result from matcher to decoder
`timescale 1ns/100ps
`default_nettype none
interface pmfd_match_if;
	import pmfd_pkg::*;
	logic             hit;
	logic             beyond;
	logic [OFS_W-1:0] ofs;
	modport src  (output hit, output beyond, output ofs);
	modport sink (input hit, input beyond, input ofs);
endinterface
`default_nettype wire

// *** shared/pmfd_pkg.sv ***
// constants and types of the peripheral memory frame decoder
package pmfd_pkg;

	localparam int ADDR_W     = 32;
	localparam int OFS_W      = 24;
	localparam int NFRAMES    = 13;
	localparam int SEL_W      = 4;

	typedef enum logic [2:0] {
		PMFD_CHECKER = 3'h0,
		PMFD_SERIAL  = 3'h1,
		PMFD_CAN     = 3'h2,
		PMFD_CONV    = 3'h3,
		PMFD_TIMER   = 3'h4,
		PMFD_XFER    = 3'h5
	} pmfd_kind_type;

	// frame table: base, span (log2 of frame size), abort limit, kind
	localparam logic [ADDR_W-1:0] FRAME_BASE [NFRAMES] = '{
		32'hFE00_0000,
		32'hFF0A_0000, 32'hFF0C_0000, 32'hFF0E_0000, 32'hFF1A_0000,
		32'hFF1C_0000, 32'hFF1E_0000,
		32'hFF3A_0000, 32'hFF3E_0000,
		32'hFF44_0000, 32'hFF46_0000,
		32'hFF4C_0000, 32'hFF4E_0000};
	localparam int FRAME_SPAN_LOG2 [NFRAMES] = '{
		24, 17, 17, 17, 17, 17, 17, 17, 17, 17, 17, 17, 17};
	localparam logic [OFS_W-1:0] CHECKER_LIMIT = 24'h00_0200;
	localparam logic [OFS_W-1:0] SERIAL_LIMIT  = 24'h00_0800;
	localparam logic [OFS_W-1:0] CAN_LIMIT     = 24'h00_0800;
	localparam logic [OFS_W-1:0] CONV_LIMIT    = 24'h00_4000;
	localparam logic [OFS_W-1:0] TIMER_LIMIT   = 24'h00_4000;
	localparam logic [OFS_W-1:0] XFER_LIMIT    = 24'h00_0400;
	localparam logic [OFS_W-1:0] FRAME_LIMIT [NFRAMES] = '{
		CHECKER_LIMIT,
		SERIAL_LIMIT, SERIAL_LIMIT, SERIAL_LIMIT, SERIAL_LIMIT,
		CAN_LIMIT, CAN_LIMIT,
		CONV_LIMIT, CONV_LIMIT,
		TIMER_LIMIT, TIMER_LIMIT,
		XFER_LIMIT, XFER_LIMIT};
	localparam pmfd_kind_type FRAME_KIND [NFRAMES] = '{
		PMFD_CHECKER,
		PMFD_SERIAL, PMFD_SERIAL, PMFD_SERIAL, PMFD_SERIAL,
		PMFD_CAN, PMFD_CAN,
		PMFD_CONV, PMFD_CONV,
		PMFD_TIMER, PMFD_TIMER,
		PMFD_XFER, PMFD_XFER};

	// wrap masks onto the implemented storage
	localparam logic [OFS_W-1:0] CAN_WRAP_MASK   = 24'h00_07FF;
	localparam logic [OFS_W-1:0] CONV_RAM_MASK   = 24'h00_1FFF;
	localparam logic [OFS_W-1:0] TIMER_WRAP_MASK = 24'h00_3FFF;

	// converter look-up table: 384 bytes = 3 chunks of 128 bytes
	localparam logic [OFS_W-1:0] LUT_START       = 24'h00_2000;
	localparam int               LUT_CHUNK_LOG2  = 7;
	localparam int               LUT_CHUNKS      = 3;
	localparam int               LUT_REL_W       = 13;

endpackage

// *** verification/pmfd_master_model.sv ***
// bus master issuing single accesses to the frame decoder
`timescale 1ns/100ps
`default_nettype none
module pmfd_master_model import pmfd_pkg::*; (
	// clock and answers
	input  wire logic              I_SYS_CLK,
	input  wire logic              O_FWD_VALID,
	input  wire logic              O_RSP_ERROR,
	input  wire logic              O_REQ_MISS,
	// request
	output logic                   I_REQ_VALID,
	output logic [ADDR_W-1:0]      I_REQ_ADDR,
	output logic                   I_REQ_WRITE,
	output logic [31:0]            I_REQ_WDATA,
	output logic [3:0]             I_REQ_BE
);
	initial {I_REQ_VALID, I_REQ_ADDR, I_REQ_WRITE, I_REQ_WDATA, I_REQ_BE} = '0;
	// result: 0 forwarded, 1 failed, 2 unmapped, 3 nothing
	task automatic access(input logic [ADDR_W-1:0] a, output logic [1:0] r);
		@(negedge I_SYS_CLK);
		I_REQ_VALID = 1'b1;
		I_REQ_ADDR = a;
		I_REQ_WDATA = $urandom;
		{I_REQ_WRITE, I_REQ_BE} = 5'($urandom);
		@(negedge I_SYS_CLK);
		I_REQ_VALID = 1'b0;
		I_REQ_ADDR = ~a;
		r = O_FWD_VALID ? 2'h0 : O_RSP_ERROR ? 2'h1 : O_REQ_MISS ? 2'h2 : 2'h3;
	endtask
endmodule // pmfd_master_model
`default_nettype wire

// *** verification/pmfd_properties.sv ***
// port assertions of the frame decoder
`timescale 1ns/100ps
`default_nettype none
module pmfd_properties import pmfd_pkg::*; (
	// clock, reset, request
	input wire logic              I_SYS_CLK,
	input wire logic              I_NRST,
	input wire logic              I_CKE,
	input wire logic              I_REQ_VALID,
	input wire logic [ADDR_W-1:0] I_REQ_ADDR,
	// answers
	input wire logic              O_RSP_VALID,
	input wire logic              O_RSP_ERROR,
	input wire logic              O_FWD_VALID,
	input wire logic              O_FWD_LUT,
	input wire logic [OFS_W-1:0]  O_FWD_OFS
);
	wire logic        tk  = I_REQ_VALID && I_CKE;
	wire logic [14:0] f   = I_REQ_ADDR[31:17];
	wire logic [16:0] o   = I_REQ_ADDR[16:0];
	wire logic        ser = f inside {15'h7F85, 15'h7F86, 15'h7F87, 15'h7F8D};
	wire logic        can = f == 15'h7F8E || f == 15'h7F8F;
	wire logic        cnv = f == 15'h7F9D || f == 15'h7F9F;
	wire logic        tmr = f == 15'h7FA2 || f == 15'h7FA3;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	property p_chk; tk && I_REQ_ADDR[31:24] == 8'hFE && I_REQ_ADDR[23:9] != 15'h0
		|=> O_RSP_VALID && O_RSP_ERROR && !O_FWD_VALID; endproperty
	a_chk: assert property (p_chk) else $error("checker frame abort");
	property p_ser; tk && ser && o >= 17'h800 |=> O_RSP_ERROR; endproperty
	a_ser: assert property (p_ser) else $error("serial abort");
	property p_can_wrap; tk && can && o < 17'h800 |=> O_FWD_OFS == 24'($past(o)); endproperty
	a_can_wrap: assert property (p_can_wrap) else $error("can wrap");
	property p_can_ab; tk && can && o >= 17'h800 |=> O_RSP_ERROR; endproperty
	a_can_ab: assert property (p_can_ab) else $error("can abort");
	property p_conv; tk && cnv && o < 17'h2000 |=> !O_FWD_LUT && O_FWD_OFS == 24'($past(o));
	endproperty
	a_conv: assert property (p_conv) else $error("converter ram");
	property p_lut; tk && cnv && o[16:13] == 4'h1 |=> O_FWD_VALID && O_FWD_LUT
		&& O_FWD_OFS < 24'h180 && O_FWD_OFS[6:0] == 7'($past(o)); endproperty
	a_lut: assert property (p_lut) else $error("table wrap");
	property p_conv_ab; tk && cnv && o[16:14] != 3'h0 |=> O_RSP_ERROR; endproperty
	a_conv_ab: assert property (p_conv_ab) else $error("table abort");
	property p_tmr; tk && tmr |=> O_RSP_ERROR == ($past(o) >= 17'h4000)
		&& (O_RSP_ERROR || O_FWD_OFS == 24'($past(o))); endproperty
	a_tmr: assert property (p_tmr) else $error("timer ram");
	c_can: cover property (tk && can && o >= 17'h800);
	c_lut: cover property (tk && cnv && o[16:13] == 4'h1);
	c_tmr: cover property (tk && tmr);
endmodule // pmfd_properties
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench of the frame decoder
`timescale 1ns/100ps
`default_nettype none
module tb import pmfd_pkg::*;;
	logic I_SYS_CLK = 0, I_NRST = 0, I_CKE = 1, I_REQ_VALID, I_REQ_WRITE;
	logic O_RSP_VALID, O_RSP_ERROR, O_REQ_MISS, O_FWD_VALID, O_FWD_LUT, O_FWD_WRITE;
	logic [ADDR_W-1:0] I_REQ_ADDR;
	logic [31:0] I_REQ_WDATA, O_FWD_WDATA;
	logic [3:0] I_REQ_BE, O_FWD_BE, O_FWD_SEL;
	logic [OFS_W-1:0] O_FWD_OFS;
	int miscompares = 0, checks = 0, cyc = 0;
	localparam logic [14:0] FR [12] = '{15'h7F85, 15'h7F86, 15'h7F87, 15'h7F8D, 15'h7F8E,
		15'h7F8F, 15'h7F9D, 15'h7F9F, 15'h7FA2, 15'h7FA3, 15'h7FA6, 15'h7FA7};
	localparam logic [16:0] LM [12] = '{17'h800, 17'h800, 17'h800, 17'h800, 17'h800,
		17'h800, 17'h4000, 17'h4000, 17'h4000, 17'h4000, 17'h400, 17'h400};
	localparam logic [31:0] CORNER [19] = '{32'hFE00_01FF, 32'hFE00_0200, 32'hFEFF_FFFC,
		32'hFF0A_07FF, 32'hFF1A_0800, 32'hFF1C_07FF, 32'hFF1E_0800, 32'hFF3A_1FFF,
		32'hFF3A_2000, 32'hFF3E_217F, 32'hFF3A_2180, 32'hFF3E_3FFF, 32'hFF3A_4000,
		32'hFF44_3FFF, 32'hFF46_4000, 32'hFF4C_03FF, 32'hFF4E_0400, 32'hFF30_0000,
		32'hFF3A_2190};
	pmfd_decoder pmfd_decoder_inst (.*);
	pmfd_master_model pmfd_master_model_inst (.*);
	// {result, frame, table, offset}
	function automatic logic [30:0] expect_of(logic [31:0] a);
		logic [16:0] o;
		o = a[16:0];
		if (a[31:24] == 8'hFE)
			return (a[23:0] >= 24'h200) ? {2'h1, 29'h0} : {7'h0, a[23:0]};
		for (int k = 0; k < 12; k++)
			if (a[31:17] == FR[k])
				return (o >= LM[k]) ? {2'h1, 29'h0} : (k > 5 && k < 8 && o[13]) ?
					{2'h0, 4'(k + 1), 1'b1, 11'h0, 6'(o[12:7] % 3), o[6:0]} :
					{2'h0, 4'(k + 1), 1'b0, 7'h0, o};
		return {2'h2, 29'h0};
	endfunction
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic run(logic [31:0] a);
		logic [1:0] r;
		logic [30:0] e;
		e = expect_of(a);
		pmfd_master_model_inst.access(a, r);
		chk("result", 32'(r), 32'(e[30:29]));
		// every answer pulse on its own, so a double answer cannot hide
		chk("rsp_valid", 32'(O_RSP_VALID), 32'(e[30:29] == 2'h1));
		chk("rsp_error", 32'(O_RSP_ERROR), 32'(e[30:29] == 2'h1));
		chk("miss", 32'(O_REQ_MISS), 32'(e[30:29] == 2'h2));
		chk("fwd_valid", 32'(O_FWD_VALID), 32'(e[30:29] == 2'h0));
		if (e[30:29] == 2'h0) begin
			chk("target", {3'h0, O_FWD_SEL, O_FWD_LUT, O_FWD_OFS}, 32'(e[28:0]));
			chk("fwd_ctl", {27'h0, O_FWD_WRITE, O_FWD_BE}, {27'h0, I_REQ_WRITE, I_REQ_BE});
			chk("fwd_wdata", O_FWD_WDATA, I_REQ_WDATA);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always #2 I_SYS_CLK = ~I_SYS_CLK;
	// a hang cannot outlast this many cycles
	always @(posedge I_SYS_CLK) if (++cyc == 5000) begin
		miscompares++;
		complete_run();
	end
	initial begin
		logic [1:0] fr;
		void'($urandom(7));
		repeat (16) @(negedge I_SYS_CLK);
		I_NRST = 1;
		foreach (CORNER[i]) run(CORNER[i]);
		// let the last pulse clear before freezing
		@(negedge I_SYS_CLK);
		I_CKE = 1'b0;
		pmfd_master_model_inst.access(32'hFF46_8000, fr);
		chk("frozen", 32'(fr), 32'h3);
		I_CKE = 1'b1;
		// reset in mid-run clears every output
		I_NRST = 1'b0;
		repeat (2) @(negedge I_SYS_CLK);
		chk("reset", {O_FWD_VALID, O_RSP_VALID, O_RSP_ERROR, O_REQ_MISS, O_FWD_SEL, O_FWD_OFS},
			32'h0);
		I_NRST = 1'b1;
		foreach (CORNER[i]) run(CORNER[i]);
		repeat (300) run($urandom_range(9) ?
			{FR[$urandom_range(11)], 17'($urandom) >> $urandom_range(16)} : $urandom);
		complete_run();
	end
endmodule // tb
bind pmfd_decoder pmfd_properties pmfd_properties_inst (.*);
`default_nettype wire

// *** verilog/pmfd_decoder.sv ***
// peripheral memory frame decoder: select, wrap or abort per frame
// Functional notes
// RL1 - checker frame aborts offsets from 0x200 up
// RL2 - serial RAM frames abort offsets past 2KB
// RL3 - CAN RAM low offsets wrap onto 2KB
// RL4 - CAN RAM frames abort offsets from 0x800
// RL5 - converter RAM wraps under 0x1FFF, table beyond up to 0x3FFF
// RL6 - table region 0x2000-0x217F reaches table storage
// RL7 - table offsets up to 0x3FFF wrap onto table
// RL8 - table frame aborts offsets from 0x4000
// RL9 - timer RAM wraps under 0x3FFF, aborts beyond
// RL10 - abort returns error response; master sees failure
`timescale 1ns/100ps
`default_nettype none
module pmfd_decoder
	import pmfd_pkg::*;
(
	// clock, reset, enable
	input  wire logic              I_SYS_CLK,
	input  wire logic              I_NRST,
	input  wire logic              I_CKE,
	// master request
	input  wire logic              I_REQ_VALID,
	input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
	input  wire logic              I_REQ_WRITE,
	input  wire logic [31:0]       I_REQ_WDATA,
	input  wire logic [3:0]        I_REQ_BE,
	// master response
	output logic                   O_RSP_VALID,
	output logic                   O_RSP_ERROR,
	output logic                   O_REQ_MISS,
	// forwarded access to the selected memory
	output logic                   O_FWD_VALID,
	output logic [SEL_W-1:0]       O_FWD_SEL,
	output logic                   O_FWD_LUT,
	output logic [OFS_W-1:0]       O_FWD_OFS,
	output logic                   O_FWD_WRITE,
	output logic [31:0]            O_FWD_WDATA,
	output logic [3:0]             O_FWD_BE
);
	pmfd_match_if match [NFRAMES] ();

	genvar g;
	generate
		for (g = 0; g < NFRAMES; g++) begin : g_frame
			pmfd_frame_match #(
				.BASE      (FRAME_BASE[g]),
				.SPAN_LOG2 (FRAME_SPAN_LOG2[g]),
				.LIMIT     (FRAME_LIMIT[g])
			) u_match (
				.i_addr  (I_REQ_ADDR),
				.o_match (match[g])
			);
		end
	endgenerate

	logic [NFRAMES-1:0] hit_vec;
	logic [NFRAMES-1:0] beyond_vec;
	logic [OFS_W-1:0]   ofs_arr [NFRAMES];

	generate
		for (g = 0; g < NFRAMES; g++) begin : g_flat
			assign hit_vec[g]    = match[g].hit;
			assign beyond_vec[g] = match[g].beyond;
			assign ofs_arr[g]    = match[g].ofs;
		end
	endgenerate

	// table wrap: offset modulo 384 is (chunk mod 3, byte within chunk)
	function automatic logic [OFS_W-1:0] lut_wrap(input logic [OFS_W-1:0] ofs);
		logic [LUT_REL_W-LUT_CHUNK_LOG2-1:0] chunk;
		logic [1:0]                          chunk_mod;
		chunk     = ofs[LUT_REL_W-1:LUT_CHUNK_LOG2];
		chunk_mod = 2'(chunk % LUT_CHUNKS);
		lut_wrap  = {{(OFS_W-LUT_CHUNK_LOG2-2){1'b0}}, chunk_mod,
			ofs[LUT_CHUNK_LOG2-1:0]};
	endfunction

	// decode of the current request
	logic             dec_hit;
	logic             dec_abort;
	logic [SEL_W-1:0] dec_sel;
	logic             dec_lut;
	logic [OFS_W-1:0] dec_ofs;

	always_comb begin
		dec_hit   = 1'b0;
		dec_abort = 1'b0;
		dec_sel   = '0;
		dec_lut   = 1'b0;
		dec_ofs   = '0;
		for (int i = 0; i < NFRAMES; i++) begin
			if (hit_vec[i]) begin
				dec_hit   = 1'b1;
				dec_sel   = SEL_W'(i);
				dec_abort = beyond_vec[i]; // see RL1 see RL2 see RL4 see RL8
				case (FRAME_KIND[i])
					PMFD_CAN: begin
						dec_ofs = ofs_arr[i] & CAN_WRAP_MASK; // see RL3
					end
					PMFD_CONV: begin
						if (ofs_arr[i] < LUT_START) begin
							dec_ofs = ofs_arr[i] & CONV_RAM_MASK; // see RL5
						end else begin
							dec_lut = 1'b1; // see RL6
							dec_ofs = lut_wrap(ofs_arr[i]); // see RL7
						end
					end
					PMFD_TIMER: begin
						dec_ofs = ofs_arr[i] & TIMER_WRAP_MASK; // see RL9
					end
					default: begin
						dec_ofs = ofs_arr[i];
					end
				endcase
			end
		end
	end

	// response and forward state
	logic             rsp_valid_r, rsp_valid_nxt;
	logic             rsp_error_r, rsp_error_nxt;
	logic             miss_r, miss_nxt;
	logic             fwd_valid_r, fwd_valid_nxt;
	logic [SEL_W-1:0] fwd_sel_r, fwd_sel_nxt;
	logic             fwd_lut_r, fwd_lut_nxt;
	logic [OFS_W-1:0] fwd_ofs_r, fwd_ofs_nxt;
	logic             fwd_write_r, fwd_write_nxt;
	logic [31:0]      fwd_wdata_r, fwd_wdata_nxt;
	logic [3:0]       fwd_be_r, fwd_be_nxt;

	always_comb begin
		rsp_valid_nxt = 1'b0;
		rsp_error_nxt = 1'b0;
		miss_nxt      = 1'b0;
		fwd_valid_nxt = 1'b0;
		fwd_sel_nxt   = fwd_sel_r;
		fwd_lut_nxt   = fwd_lut_r;
		fwd_ofs_nxt   = fwd_ofs_r;
		fwd_write_nxt = fwd_write_r;
		fwd_wdata_nxt = fwd_wdata_r;
		fwd_be_nxt    = fwd_be_r;
		if (I_REQ_VALID) begin
			if (!dec_hit) begin
				// outside every frame: left to another decoder
				miss_nxt = 1'b1;
			end else if (dec_abort) begin
				// aborted access never reaches a memory
				rsp_valid_nxt = 1'b1;
				rsp_error_nxt = 1'b1; // see RL10
			end else begin
				fwd_valid_nxt = 1'b1;
				fwd_sel_nxt   = dec_sel;
				fwd_lut_nxt   = dec_lut;
				fwd_ofs_nxt   = dec_ofs;
				fwd_write_nxt = I_REQ_WRITE;
				fwd_wdata_nxt = I_REQ_WDATA;
				fwd_be_nxt    = I_REQ_BE;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		// reset waits for the enable too: a low enable freezes everything
		if (I_CKE && !I_NRST) begin
			rsp_valid_r <= 1'b0;
			rsp_error_r <= 1'b0;
			miss_r      <= 1'b0;
			fwd_valid_r <= 1'b0;
			fwd_sel_r   <= '0;
			fwd_lut_r   <= 1'b0;
			fwd_ofs_r   <= '0;
			fwd_write_r <= 1'b0;
			fwd_wdata_r <= '0;
			fwd_be_r    <= '0;
		end else if (I_CKE) begin
			rsp_valid_r <= rsp_valid_nxt;
			rsp_error_r <= rsp_error_nxt;
			miss_r      <= miss_nxt;
			fwd_valid_r <= fwd_valid_nxt;
			fwd_sel_r   <= fwd_sel_nxt;
			fwd_lut_r   <= fwd_lut_nxt;
			fwd_ofs_r   <= fwd_ofs_nxt;
			fwd_write_r <= fwd_write_nxt;
			fwd_wdata_r <= fwd_wdata_nxt;
			fwd_be_r    <= fwd_be_nxt;
		end
	end

	assign O_RSP_VALID = rsp_valid_r;
	assign O_RSP_ERROR = rsp_error_r;
	assign O_REQ_MISS  = miss_r;
	assign O_FWD_VALID = fwd_valid_r;
	assign O_FWD_SEL   = fwd_sel_r;
	assign O_FWD_LUT   = fwd_lut_r;
	assign O_FWD_OFS   = fwd_ofs_r;
	assign O_FWD_WRITE = fwd_write_r;
	assign O_FWD_WDATA = fwd_wdata_r;
	assign O_FWD_BE    = fwd_be_r;
endmodule // pmfd_decoder
`default_nettype wire

// *** verilog/pmfd_frame_match.sv ***
// address match of one peripheral memory frame
`timescale 1ns/100ps
`default_nettype none
module pmfd_frame_match
	import pmfd_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE      = 32'h0000_0000,
	parameter int                SPAN_LOG2 = 17,
	parameter logic [OFS_W-1:0]  LIMIT     = 24'h00_0800
) (
	// request address
	input  wire logic [ADDR_W-1:0] i_addr,
	// match result
	pmfd_match_if.src              o_match
);
	logic [ADDR_W-1:0] rel;

	always_comb begin
		rel           = i_addr - BASE;
		o_match.hit    = (rel >> SPAN_LOG2) == '0;
		o_match.ofs    = rel[OFS_W-1:0];
		// offsets at or past the limit are not implemented and fault
		o_match.beyond = rel[OFS_W-1:0] >= LIMIT;
	end
endmodule // pmfd_frame_match
`default_nettype wire
